/* File: hdl/dmr_ctrl.sv */
// dmr_ctrl: mode register, refresh timer and power sequencing, one channel
// assumes clk_dram from the memory side, unrelated in phase to clk_sys
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Overview of operation
// RQ1 - init done flag bit 29, software only
// RQ2 - refresh select bits 10:8, 000 disables
// RQ3 - 001 gives 15.6 us, 010 gives 7.8 us
// RQ4 - 011 gives 3.9 us, 100 gives 1.95 us
// RQ5 - 111 refreshes every 64 clocks; 101/110 reserved
// RQ6 - special select bits 6:4 cleared by reset
// RQ7 - clock enables low while reset held
// RQ8 - clock enables rise on nonzero special write
// RQ9 - suspend flushes, then all ranks self-refresh
// RQ10 - resume reset clears field, enables stay low
// RQ11 - low-power entry flushes, then enters self-refresh
// RQ12 - low-power exit leaves self-refresh without software
// RQ13 - special 001 turns accesses into nop
// RQ14 - special 010 turns accesses into precharge-all
// RQ15 - 011/100 give mode or extended mode set
// RQ16 - 110 gives auto-refresh; 111 normal access
// RQ17 - interval count from rate, restarted per refresh
module dmr_ctrl
  import dmr_pkg::*;
#(
  parameter int RANKS    = 4,
  parameter int ADDR_LSB = 3
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   clk_dram,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [11:0]            reg_addr,
  input  wire logic [31:0]            reg_wdata,
  output logic      [31:0]            reg_rdata,
  input  wire logic                   cpu_req,
  input  wire logic                   cpu_we,
  input  wire logic [31:0]            cpu_addr,
  output logic                        cpu_ready,
  input  wire logic                   suspend_req,
  input  wire logic                   lowpwr_req,
  output logic                        self_refresh,
  output logic      [RANKS-1:0]       dram_cke,
  output dmr_cmd_t                    dram_cmd,
  output logic      [DMR_DADDR_W-1:0] dram_addr,
  output logic      [2:0]             dram_ba
);

  // ====================================================================
  // crossing and synchronisers
  dmr_cross_if xif ();

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic       cpu_ack_s;
  logic       ref_ack_s;
  logic       sr_done_s;

  assign {cpu_ack_s, ref_ack_s, sr_done_s} = sync_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else begin
      meta_reg <= {xif.cpu_ack, xif.ref_ack, xif.sr_done};
      sync_reg <= meta_reg;
    end
  end

  // ====================================================================
  // mode register
  logic        init_reg, init_next;
  logic [2:0]  rate_reg, rate_next;
  dmr_spec_t   spec_reg, spec_next;
  logic        cke_on_reg, cke_on_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] mode_word;
  logic        mode_hit;
  logic        wr_init;
  logic [2:0]  wr_spec;

  assign mode_hit = (reg_addr == DMR_MODE_ADDR);
  assign wr_init  = reg_wdata[DMR_INIT_BIT];
  assign wr_spec  = reg_wdata[DMR_SPEC_LSB +: 3];

  always_comb begin
    mode_word                     = 32'h0000_0000;
    mode_word[DMR_INIT_BIT]       = init_reg;
    mode_word[DMR_RATE_LSB +: 3]  = rate_reg;
    mode_word[DMR_SPEC_LSB +: 3]  = spec_reg;
    init_next   = init_reg;
    rate_next   = rate_reg;
    spec_next   = spec_reg;
    cke_on_next = cke_on_reg;
    rdata_next  = 32'h0000_0000;
    if (reg_wr && mode_hit) begin
      init_next = wr_init;  // [RQ1]
      rate_next = reg_wdata[DMR_RATE_LSB +: 3];  // [RQ2]
      spec_next = dmr_spec_t'(wr_spec);
      if (wr_spec != SP_POST) begin
        cke_on_next = 1'h1;  // [RQ8]
      end
    end
    if (reg_rd && mode_hit) begin
      rdata_next = mode_word;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      init_reg   <= DMR_INIT_RST;
      rate_reg   <= DMR_RATE_RST;
      spec_reg   <= SP_POST;  // [RQ6] [RQ10]
      cke_on_reg <= 1'h0;  // [RQ7] [RQ10]
      rdata_reg  <= 32'h0000_0000;
    end else begin
      init_reg   <= init_next;
      rate_reg   <= rate_next;
      spec_reg   <= spec_next;
      cke_on_reg <= cke_on_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ====================================================================
  // refresh interval timer
  function automatic logic [11:0] term_count(input logic [2:0] rate);
    logic [11:0] cnt;
    cnt = 12'h000;
    unique case (rate)
      RATE_156:  cnt = DMR_CNT_156;  // [RQ3]
      RATE_78:   cnt = DMR_CNT_78;  // [RQ3]
      RATE_39:   cnt = DMR_CNT_39;  // [RQ4]
      RATE_195:  cnt = DMR_CNT_195;  // [RQ4]
      RATE_FAST: cnt = DMR_CNT_FAST;  // [RQ5]
      default:   cnt = 12'h000;  // [RQ2] [RQ5]
    endcase
    return cnt;
  endfunction

  dmr_pwr_t    pwr_reg, pwr_next;
  logic [11:0] ref_term;
  logic [11:0] ref_cnt_reg, ref_cnt_next;
  logic        ref_tgl_reg, ref_tgl_next;
  logic        ref_busy;
  logic        ref_on;

  assign ref_term = term_count(rate_reg);
  assign ref_busy = (ref_tgl_reg != ref_ack_s);
  assign ref_on   = (ref_term != 12'h000) && (pwr_reg == PWR_RUN);

  always_comb begin
    ref_cnt_next = ref_cnt_reg;
    ref_tgl_next = ref_tgl_reg;
    if (!ref_on) begin
      ref_cnt_next = 12'h000;  // [RQ2]
    end else if (ref_cnt_reg >= ref_term - 12'h001) begin
      if (!ref_busy) begin
        ref_tgl_next = !ref_tgl_reg;
        ref_cnt_next = 12'h000;  // [RQ17]
      end
    end else begin
      ref_cnt_next = ref_cnt_reg + 12'h001;  // [RQ17]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_cnt_reg <= 12'h000;
      ref_tgl_reg <= 1'h0;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
      ref_tgl_reg <= ref_tgl_next;
    end
  end

  // ====================================================================
  // processor access translation
  function automatic dmr_cmd_t map_cmd(input dmr_spec_t spec,
                                       input logic      we);
    dmr_cmd_t cmd;
    cmd = CMD_NOP;
    unique case (spec)
      SP_POST:   cmd = CMD_NOP;
      SP_NOP:    cmd = CMD_NOP;  // [RQ13]
      SP_PALL:   cmd = CMD_PALL;  // [RQ14]
      SP_MRS:    cmd = CMD_MRS;  // [RQ15]
      SP_EMRS:   cmd = CMD_EMRS;  // [RQ15]
      SP_RSV:    cmd = CMD_NOP;
      SP_REF:    cmd = CMD_REF;  // [RQ16]
      SP_NORMAL: cmd = we ? CMD_WR : CMD_RD;  // [RQ16]
    endcase
    return cmd;
  endfunction

  logic                   cpu_tgl_reg, cpu_tgl_next;
  dmr_cmd_t               cpu_cmd_reg, cpu_cmd_next;
  logic [DMR_DADDR_W-1:0] cpu_daddr_reg, cpu_daddr_next;
  logic                   cpu_busy;

  assign cpu_busy  = (cpu_tgl_reg != cpu_ack_s);
  assign cpu_ready = (pwr_reg == PWR_RUN) && !cpu_busy;  // [RQ9]

  always_comb begin
    cpu_tgl_next   = cpu_tgl_reg;
    cpu_cmd_next   = cpu_cmd_reg;
    cpu_daddr_next = cpu_daddr_reg;
    if (cpu_req && cpu_ready) begin
      cpu_tgl_next   = !cpu_tgl_reg;
      cpu_cmd_next   = map_cmd(spec_reg, cpu_we);
      cpu_daddr_next = cpu_addr[ADDR_LSB +: DMR_DADDR_W];  // [RQ15]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_tgl_reg   <= 1'h0;
      cpu_cmd_reg   <= CMD_NOP;
      cpu_daddr_reg <= 14'h0000;
    end else begin
      cpu_tgl_reg   <= cpu_tgl_next;
      cpu_cmd_reg   <= cpu_cmd_next;
      cpu_daddr_reg <= cpu_daddr_next;
    end
  end

  // ====================================================================
  // power sequencing
  logic sr_req_reg, sr_req_next;
  logic susp_reg, susp_next;
  logic flush_idle;

  assign flush_idle = (pwr_reg == PWR_FLUSH) && !cpu_busy && !ref_busy;

  always_comb begin
    pwr_next    = pwr_reg;
    sr_req_next = sr_req_reg;
    susp_next   = susp_reg | suspend_req;
    unique case (pwr_reg)
      PWR_RUN: begin
        if (suspend_req || lowpwr_req) begin
          pwr_next = PWR_FLUSH;
        end
      end
      PWR_FLUSH: begin
        if (flush_idle) begin
          sr_req_next = 1'h1;  // [RQ9] [RQ11]
          pwr_next    = PWR_SELF;
        end
      end
      PWR_SELF: begin
        if (!susp_reg && !lowpwr_req && sr_done_s) begin
          sr_req_next = 1'h0;  // [RQ12]
          pwr_next    = PWR_EXIT;
        end
      end
      PWR_EXIT: begin
        if (!sr_done_s) begin
          pwr_next = PWR_RUN;  // [RQ12]
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_reg    <= PWR_RUN;
      sr_req_reg <= 1'h0;
      susp_reg   <= 1'h0;  // [RQ10]
    end else begin
      pwr_reg    <= pwr_next;
      sr_req_reg <= sr_req_next;
      susp_reg   <= susp_next;
    end
  end

  assign self_refresh = sr_done_s;

  // ====================================================================
  // link side
  assign xif.cpu_tgl  = cpu_tgl_reg;
  assign xif.cpu_cmd  = cpu_cmd_reg;
  assign xif.cpu_addr = cpu_daddr_reg;
  assign xif.ref_tgl  = ref_tgl_reg;
  assign xif.cke_on   = cke_on_reg;
  assign xif.sr_req   = sr_req_reg;

  dmr_link #(
    .RANKS     (RANKS)
  ) u_link (
    .clk_dram  (clk_dram),
    .rst       (rst),
    .xif       (xif.lnk),
    .dram_cke  (dram_cke),
    .dram_cmd  (dram_cmd),
    .dram_addr (dram_addr),
    .dram_ba   (dram_ba)
  );

  // ====================================================================
  // checks
  default clocking sys_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_init_write: assert property ( // [RQ1]
    reg_wr && mode_hit |=> init_reg == $past(wr_init))
    else $error("init flag not written");

  chk_rate_off: assert property ( // [RQ2]
    rate_reg == RATE_OFF |=> ref_cnt_reg == 12'h000 && $stable(ref_tgl_reg))
    else $error("refresh issued while disabled");

  chk_ref_issue: assert property ( // [RQ3] [RQ4] [RQ5] [RQ17]
    ref_on && !ref_busy && ref_cnt_reg == ref_term - 12'h001
    |=> ref_cnt_reg == 12'h000 && $changed(ref_tgl_reg))
    else $error("refresh not issued at terminal count");

  chk_spec_cleared: assert property ( // [RQ6] [RQ10]
    !cke_on_reg |-> spec_reg == SP_POST)
    else $error("clock enable off with special field set");

  chk_cke_on_write: assert property ( // [RQ8]
    reg_wr && mode_hit && wr_spec != 3'h0 |=> cke_on_reg)
    else $error("clock enable not released by write");

  chk_cke_sticky: assert property ( // [RQ8]
    $past(cke_on_reg) |-> cke_on_reg)
    else $error("clock enable dropped without reset");

  chk_flush_first: assert property ( // [RQ9] [RQ11]
    $rose(sr_req_reg) |-> $past(flush_idle))
    else $error("self-refresh requested before flush");

  chk_no_accept: assert property ( // [RQ9]
    pwr_reg != PWR_RUN |-> !cpu_ready)
    else $error("access accepted outside run");

  chk_suspend_hold: assert property ( // [RQ10]
    susp_reg && pwr_reg == PWR_SELF |=> pwr_reg == PWR_SELF)
    else $error("left self-refresh after suspend");

  chk_lp_exit: assert property ( // [RQ12]
    pwr_reg == PWR_SELF && !susp_reg && !lowpwr_req && sr_done_s
    |=> !sr_req_reg ##[1:20] pwr_reg == PWR_RUN)
    else $error("low-power exit not automatic");

  chk_nop_map: assert property ( // [RQ13]
    cpu_req && cpu_ready && spec_reg == SP_NOP |=> cpu_cmd_reg == CMD_NOP)
    else $error("nop mode mapping wrong");

  chk_pall_map: assert property ( // [RQ14]
    cpu_req && cpu_ready && spec_reg == SP_PALL |=> cpu_cmd_reg == CMD_PALL)
    else $error("precharge mode mapping wrong");

  chk_emrs_map: assert property ( // [RQ15]
    cpu_req && cpu_ready && spec_reg == SP_EMRS |=> cpu_cmd_reg == CMD_EMRS)
    else $error("extended mode set mapping wrong");

  chk_write_map: assert property ( // [RQ16]
    cpu_req && cpu_ready && spec_reg == SP_NORMAL && cpu_we
    |=> cpu_cmd_reg == CMD_WR)
    else $error("normal write mapping wrong");

endmodule
`default_nettype wire

/* File: hdl/dmr_pkg.sv */
// dmr_pkg: register map, timing counts and types of the dram mode block
// assumes a 32-bit register word and a 20 MHz system clock
package dmr_pkg;
  // ===================================================================
  // register map
  localparam logic [11:0] DMR_MODE_ADDR = 12'h120;
  localparam int          DMR_INIT_BIT  = 29;
  localparam int          DMR_RATE_LSB  = 8;
  localparam int          DMR_SPEC_LSB  = 4;
  localparam logic        DMR_INIT_RST  = 1'h0;
  localparam logic [2:0]  DMR_RATE_RST  = 3'h0;
  localparam int          DMR_DADDR_W   = 14;
  localparam logic [2:0]  DMR_BA_MRS    = 3'h0;
  localparam logic [2:0]  DMR_BA_EMRS   = 3'h1;
  // ===================================================================
  // refresh rate codes
  localparam logic [2:0]  RATE_OFF      = 3'h0;
  localparam logic [2:0]  RATE_156      = 3'h1;
  localparam logic [2:0]  RATE_78       = 3'h2;
  localparam logic [2:0]  RATE_39       = 3'h3;
  localparam logic [2:0]  RATE_195      = 3'h4;
  localparam logic [2:0]  RATE_FAST     = 3'h7;
  // ===================================================================
  // timing
  localparam int          DMR_CLK_NS    = 50;
  localparam int          DMR_T156_NS   = 15600;
  localparam int          DMR_T78_NS    = 7800;
  localparam int          DMR_T39_NS    = 3900;
  localparam int          DMR_T195_NS   = 1950;
  localparam int          DMR_FAST_CLKS = 64;
  localparam logic [11:0] DMR_CNT_156   = 12'(DMR_T156_NS / DMR_CLK_NS);
  localparam logic [11:0] DMR_CNT_78    = 12'(DMR_T78_NS / DMR_CLK_NS);
  localparam logic [11:0] DMR_CNT_39    = 12'(DMR_T39_NS / DMR_CLK_NS);
  localparam logic [11:0] DMR_CNT_195   = 12'(DMR_T195_NS / DMR_CLK_NS);
  localparam logic [11:0] DMR_CNT_FAST  = 12'(DMR_FAST_CLKS);
  // ===================================================================
  // types
  typedef enum logic [2:0] {
    SP_POST   = 3'b000,
    SP_NOP    = 3'b001,
    SP_PALL   = 3'b010,
    SP_MRS    = 3'b011,
    SP_EMRS   = 3'b100,
    SP_RSV    = 3'b101,
    SP_REF    = 3'b110,
    SP_NORMAL = 3'b111
  } dmr_spec_t;
  typedef enum logic [2:0] {
    CMD_NOP  = 3'b000,
    CMD_PALL = 3'b001,
    CMD_MRS  = 3'b010,
    CMD_EMRS = 3'b011,
    CMD_REF  = 3'b100,
    CMD_RD   = 3'b101,
    CMD_WR   = 3'b110,
    CMD_SRE  = 3'b111
  } dmr_cmd_t;
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_FLUSH = 2'b01,
    PWR_SELF  = 2'b10,
    PWR_EXIT  = 2'b11
  } dmr_pwr_t;
endpackage

/* File: hdl/dmr_cross_if.sv */
// dmr_cross_if: signals crossing between system and dram clock domains
// assumes toggles and levels are synchronised by the receiving side
`timescale 1ns/1ps
`default_nettype none
interface dmr_cross_if;
  import dmr_pkg::*;
  logic                   cpu_tgl;
  dmr_cmd_t               cpu_cmd;
  logic [DMR_DADDR_W-1:0] cpu_addr;
  logic                   ref_tgl;
  logic                   cke_on;
  logic                   sr_req;
  logic                   cpu_ack;
  logic                   ref_ack;
  logic                   sr_done;
  modport sys (output cpu_tgl, cpu_cmd, cpu_addr, ref_tgl, cke_on, sr_req,
               input cpu_ack, ref_ack, sr_done);
  modport lnk (input cpu_tgl, cpu_cmd, cpu_addr, ref_tgl, cke_on, sr_req,
               output cpu_ack, ref_ack, sr_done);
endinterface
`default_nettype wire

/* File: hdl/dmr_link.sv */
// dmr_link: dram-clock command issue, clock enables, self-refresh
// assumes cpu_cmd/cpu_addr stay stable while their toggle is pending
`timescale 1ns/1ps
`default_nettype none
module dmr_link
  import dmr_pkg::*;
#(
  parameter int RANKS = 4
) (
  input  wire logic                   clk_dram,
  input  wire logic                   rst,
  dmr_cross_if.lnk                    xif,
  output logic     [RANKS-1:0]        dram_cke,
  output dmr_cmd_t                    dram_cmd,
  output logic     [DMR_DADDR_W-1:0]  dram_addr,
  output logic     [2:0]              dram_ba
);
  // ===================================================================
  // synchronisers
  logic [3:0]             meta_reg;
  logic [3:0]             sync_reg;
  logic                   cpu_s;
  logic                   ref_s;
  logic                   cke_s;
  logic                   sr_s;
  assign {cpu_s, ref_s, cke_s, sr_s} = sync_reg;
  always_ff @(posedge clk_dram or posedge rst) begin
    if (rst) begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end else begin
      meta_reg <= {xif.cpu_tgl, xif.ref_tgl, xif.cke_on, xif.sr_req};
      sync_reg <= meta_reg;
    end
  end
  // ===================================================================
  // command issue
  logic                   cpu_seen_reg, cpu_seen_next;
  logic                   ref_seen_reg, ref_seen_next;
  logic                   sr_reg, sr_next;
  logic                   cke_reg, cke_next;
  dmr_cmd_t               cmd_reg, cmd_next;
  logic [DMR_DADDR_W-1:0] addr_reg, addr_next;
  logic [2:0]             ba_reg, ba_next;
  always_comb begin
    cpu_seen_next = cpu_seen_reg;
    ref_seen_next = ref_seen_reg;
    sr_next       = sr_reg;
    cke_next      = cke_reg;
    cmd_next      = CMD_NOP;
    addr_next     = addr_reg;
    ba_next       = ba_reg;
    if (sr_s && !sr_reg) begin
      cmd_next = CMD_SRE;  // [RQ9] [RQ11]
      cke_next = 1'h0;
      sr_next  = 1'h1;
    end else if (!sr_s && sr_reg) begin
      sr_next  = 1'h0;  // [RQ12]
      cke_next = cke_s;
    end else if (!sr_reg) begin
      cke_next = cke_s;  // [RQ8]
      if (ref_s != ref_seen_reg) begin
        cmd_next      = CMD_REF;
        ref_seen_next = ref_s;
      end else if (cpu_s != cpu_seen_reg) begin
        cmd_next      = xif.cpu_cmd;
        addr_next     = xif.cpu_addr;  // [RQ15]
        ba_next       = (xif.cpu_cmd == CMD_EMRS) ? DMR_BA_EMRS : DMR_BA_MRS;
        cpu_seen_next = cpu_s;
      end
    end
  end
  always_ff @(posedge clk_dram or posedge rst) begin
    if (rst) begin
      cpu_seen_reg <= 1'h0;
      ref_seen_reg <= 1'h0;
      sr_reg       <= 1'h0;
      cke_reg      <= 1'h0;  // [RQ7]
      cmd_reg      <= CMD_NOP;
      addr_reg     <= 14'h0000;
      ba_reg       <= 3'h0;
    end else begin
      cpu_seen_reg <= cpu_seen_next;
      ref_seen_reg <= ref_seen_next;
      sr_reg       <= sr_next;
      cke_reg      <= cke_next;
      cmd_reg      <= cmd_next;
      addr_reg     <= addr_next;
      ba_reg       <= ba_next;
    end
  end
  assign dram_cke    = {RANKS{cke_reg}};
  assign dram_cmd    = cmd_reg;
  assign dram_addr   = addr_reg;
  assign dram_ba     = ba_reg;
  assign xif.cpu_ack = cpu_seen_reg;
  assign xif.ref_ack = ref_seen_reg;
  assign xif.sr_done = sr_reg;
  // ===================================================================
  // checks
  default clocking lnk_cb @(posedge clk_dram);
  endclocking
  default disable iff (rst);
  chk_sre_cke_low: assert property ( // [RQ9]
    dram_cmd == CMD_SRE |-> dram_cke == '0)
    else $error("self-refresh entry with clock enable high");
  chk_quiet_in_sr: assert property ( // [RQ11]
    sr_reg && $past(sr_reg) |-> dram_cmd == CMD_NOP)
    else $error("command issued during self-refresh");
  chk_cke_gated: assert property ( // [RQ8]
    $rose(cke_reg) |-> $past(cke_s))
    else $error("clock enable rose without enable");
  chk_sr_exit_cke: assert property ( // [RQ12]
    $fell(sr_reg) |-> cke_reg == $past(cke_s) && dram_cmd == CMD_NOP)
    else $error("self-refresh exit wrong");
endmodule
`default_nettype wire

/* File: sim/dmr_rank_model.sv */
// dmr_rank_model: behavioural ddr2 ranks watching one channel
// assumes commands and clock enables change on clk_dram only
`timescale 1ns/1ps
`default_nettype none
module dmr_rank_model
  import dmr_pkg::*;
(
  input  wire logic                   clk_dram,
  input  wire logic                   rst,
  input  wire logic [3:0]             dram_cke,
  input  wire dmr_cmd_t               dram_cmd,
  output int                          n_cmd,
  output int                          n_ref,
  output realtime                     t_prev,
  output realtime                     t_last,
  output dmr_cmd_t                    last_cmd,
  output dmr_cmd_t                    prev_cmd,
  output logic                        in_sr
);
  // ====================================================================
  // command log, refresh times, self-refresh state
  always @(posedge clk_dram or posedge rst) begin
    if (rst) begin
      n_cmd    <= 0;
      n_ref    <= 0;
      t_prev   <= 0;
      t_last   <= 0;
      last_cmd <= CMD_NOP;
      prev_cmd <= CMD_NOP;
      in_sr    <= 1'b0;
    end else begin
      if (dram_cmd != CMD_NOP) begin
        n_cmd    <= n_cmd + 1;
        prev_cmd <= last_cmd;
        last_cmd <= dram_cmd;
      end
      if (dram_cmd == CMD_REF) begin
        n_ref  <= n_ref + 1;
        t_prev <= t_last;
        t_last <= $realtime;
      end
      // ranks only sleep when entry comes with clock enables low
      if (dram_cmd == CMD_SRE && dram_cke == 4'h0)
        in_sr <= 1'b1;
      else if (dram_cke == 4'hf)
        in_sr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_dram_channel_mode_refresh_control.sv */
// tb_dram_channel_mode_refresh_control: self-checking bench of dmr_ctrl
// assumes dmr_rank_model as the ranks on the channel
`timescale 1ns/1ps
`default_nettype none
module tb_dram_channel_mode_refresh_control;
  import dmr_pkg::*;
  logic clk_sys = 0, clk_dram = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic cpu_req = 0, cpu_we = 0, suspend_req = 0, lowpwr_req = 0;
  logic        cpu_ready, self_refresh, in_sr;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, cpu_addr = '0, reg_rdata, rd;
  logic [3:0]  dram_cke;
  logic [13:0] dram_addr;
  logic [2:0]  dram_ba;
  dmr_cmd_t    dram_cmd, last_cmd, prev_cmd;
  dmr_cmd_t    exp_c [8] = '{CMD_NOP, CMD_NOP, CMD_PALL, CMD_MRS, CMD_EMRS, CMD_NOP,
                             CMD_REF, CMD_WR};
  int          exp_t [5] = '{15600, 7800, 3900, 1950, 3200};
  int          rate  [5] = '{1, 2, 3, 4, 7};
  int          n_cmd, n_ref, fails = 0, n_checks = 0, cyc = 0, k, k0, d;
  realtime     t_prev, t_last;
  initial forever #25 clk_sys = ~clk_sys;
  initial begin
    #13;
    forever #40 clk_dram = ~clk_dram;
  end
  dmr_ctrl #(.RANKS(4), .ADDR_LSB(3)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .clk_dram(clk_dram), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_ready(cpu_ready), .suspend_req(suspend_req),
    .lowpwr_req(lowpwr_req), .self_refresh(self_refresh), .dram_cke(dram_cke),
    .dram_cmd(dram_cmd), .dram_addr(dram_addr), .dram_ba(dram_ba));
  dmr_rank_model u_ranks (.clk_dram(clk_dram), .rst(rst), .dram_cke(dram_cke),
    .dram_cmd(dram_cmd), .n_cmd(n_cmd), .n_ref(n_ref), .t_prev(t_prev),
    .t_last(t_last), .last_cmd(last_cmd), .prev_cmd(prev_cmd), .in_sr(in_sr));
  // ====================================================================
  // helpers
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic reg_write(input logic [11:0] a, input logic [31:0] v);
    reg_wr = 1; reg_addr = a; reg_wdata = v; tick(1); reg_wr = 0; tick(1);
  endtask
  task automatic reg_read(input logic [11:0] a);
    reg_rd = 1; reg_addr = a; tick(1); rd = reg_rdata; reg_rd = 0; tick(1);
  endtask
  task automatic wait_sr(input logic lvl);
    k = 0;
    while (self_refresh !== lvl && k < 400) begin tick(1); k++; end
    check(k < 400, 1, "self-refresh wait");
    tick(2);  // ranks log the command one dram edge later
  endtask
  task automatic access(input logic we, input logic [31:0] a);
    cpu_we = we; cpu_addr = a; cpu_req = 1; k = 0;
    while (cpu_ready !== 1'b1 && k < 300) begin tick(1); k++; end
    check(k < 300, 1, "ready before access");
    tick(1); cpu_req = 0; k = 0;
    while (cpu_ready !== 1'b1 && k < 300) begin tick(1); k++; end
    check(k < 300, 1, "ready after access");
    tick(4);
  endtask
  // ====================================================================
  // scenarios
  task automatic t_regs();
    tick(20); check(dram_cke, 0, "cke before write");
    reg_read(DMR_MODE_ADDR); check(rd, 0, "reset value");
    reg_write(DMR_MODE_ADDR, 32'h2000_0000); reg_write(12'h124, 32'hffff_ffff);
    reg_read(DMR_MODE_ADDR); check(rd, 32'h2000_0000, "init flag");
    reg_read(12'h124); check(rd, 0, "unmapped read");
    tick(20); check(dram_cke, 0, "cke with special zero");
    reg_write(DMR_MODE_ADDR, 32'h2000_0010);
    tick(20); check(dram_cke, 4'hf, "cke released");
  endtask
  task automatic t_modes();
    for (int m = 1; m < 8; m++) begin
      if (m == 5) continue;
      reg_write(DMR_MODE_ADDR, 32'(m) << 4); k0 = n_cmd; access(1'b1, 32'h0000_2a58);
      if (m == 1) check(n_cmd - k0, 0, "nop mode");
      else check(last_cmd, exp_c[m], "mode command");
      if (m == 3 || m == 4)
        check({dram_ba, dram_addr}, {3'(m - 3), 14'h054b}, "mode address");
    end
  endtask
  task automatic t_rates();
    for (int i = 0; i < 5; i++) begin
      reg_write(DMR_MODE_ADDR, 32'h0000_0070 | (32'(rate[i]) << 8)); k0 = n_ref; k = 0;
      while (n_ref < k0 + 3 && k < 1500) begin tick(1); k++; end
      check(k < 1500, 1, "refresh wait");
      d = int'(t_last - t_prev);
      check(32'(d > exp_t[i] + 130 || d < exp_t[i] - 130), 0, "interval");
    end
    for (int r = 0; r < 6; r += 5) begin
      reg_write(DMR_MODE_ADDR, 32'h0000_0070 | (32'(r) << 8)); tick(20); k0 = n_ref;
      tick(800); check(n_ref - k0, 0, "refresh off");
    end
  endtask
  task automatic t_lowpwr();
    lowpwr_req = 1; wait_sr(1'b1);
    check({in_sr, dram_cke, cpu_ready}, {1'b1, 4'h0, 1'b0}, "low-power entry");
    lowpwr_req = 0; wait_sr(1'b0); tick(4);
    check({in_sr, dram_cke, cpu_ready}, {1'b0, 4'hf, 1'b1}, "low-power exit");
    access(1'b0, 32'h0); check(last_cmd, CMD_RD, "access after exit");
  endtask
  task automatic t_suspend();
    cpu_we = 1; cpu_req = 1; suspend_req = 1; tick(1); cpu_req = 0; suspend_req = 0;
    wait_sr(1'b1);
    check({prev_cmd, last_cmd, dram_cke}, {CMD_WR, CMD_SRE, 4'h0}, "suspend");
    rst = 1; tick(16); check(dram_cke, 0, "cke in reset");
    rst = 0; tick(20); check(dram_cke, 0, "cke after resume");
    reg_read(DMR_MODE_ADDR); check(rd, 0, "field after resume");
    k0 = n_cmd; access(1'b1, 32'h0000_0000);
    check(n_cmd - k0, 0, "access after resume");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    check(dram_cke, 0, "cke in reset");
    rst = 0;
    t_regs();
    t_modes();
    t_rates();
    t_lowpwr();
    t_suspend();
    conclude();
  end
endmodule
`default_nettype wire
